/* inc/pmsar_pkg.sv */
// Constants, field layout and state codes of the port management slice.
// Assumes a management frame engine and a register bank share these names.
// Function
// - Control bit 2 set stops far-end fault detection; read/write, resets zero.
// - Control bit 1 set suppresses the transmitter; read/write, resets zero.
// - Control bit 0 set turns indicator outputs off; read/write, resets zero.
// - Status bit 15 always reads zero: no four-pair capability.
// - Status bits 14 and 13 read one: 100 Mbit full and half duplex.
// - Status bits 12 and 11 read one: 10 Mbit full and half duplex.
// - Status bit 5 shows negotiation finished; resets zero.
// - Status bit 4 shows a far-end fault being detected; resets zero.
// - Status bit 3 reads one: negotiation capable.
// - Status bit 2 shows link up; resets zero.
// - Status bit 0 always reads zero: no extended registers.
// - Register 2 returns the upper identifier half, read only.
// - Register 3 returns the lower identifier half, read only.
// - Advertisement bit 10 offers pause ability; read/write, resets one.
// - Advertisement bits 8 and 7 offer 100 Mbit full/half; resets one.
// - Advertisement bits 6 and 5 offer 10 Mbit full/half; resets one.
// - Partner bit 10 reports partner pause capability, read only.
package pmsar_pkg;
  // Register indices on the management bus
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h01;
  localparam logic [4:0] REG_ID_HI = 5'h02;
  localparam logic [4:0] REG_ID_LO = 5'h03;
  localparam logic [4:0] REG_ADV = 5'h04;
  localparam logic [4:0] REG_LPA = 5'h05;
  // Field positions
  localparam int CTRL_FEF_DIS_BIT = 2;
  localparam int CTRL_TX_DIS_BIT = 1;
  localparam int CTRL_LED_DIS_BIT = 0;
  localparam int STAT_AN_DONE_BIT = 5;
  localparam int STAT_FEF_BIT = 4;
  localparam int STAT_LINK_BIT = 2;
  localparam int ADV_PAUSE_BIT = 10;
  localparam int ADV_100FD_BIT = 8;
  localparam int ADV_100HD_BIT = 7;
  localparam int ADV_10FD_BIT = 6;
  localparam int ADV_10HD_BIT = 5;
  localparam int LPA_PAUSE_BIT = 10;
  // Masks and reset values
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [15:0] STAT_FIXED = 16'h7808;
  localparam logic [15:0] ADV_RW_MASK = 16'h05e0;
  localparam logic [15:0] ADV_RESET = 16'h05e1;
  localparam logic [15:0] SELECTOR = 16'h0001;
  // Management frame layout
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [3:0] HEAD_LAST = 4'hb;
  localparam logic [3:0] DATA_LAST = 4'hf;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_HEAD = 3'b010,
    ST_TURN = 3'b011,
    ST_DATA = 3'b100
  } pmsar_state_t;
endpackage

/* inc/pmsar_mgmt_if.sv */
// Register access path between the frame engine and the register bank.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface pmsar_mgmt_if;
  logic [4:0] addr;
  logic wr_stb;
  logic [15:0] wr_data;
  logic [15:0] rd_data;

  modport engine (output addr, output wr_stb, output wr_data, input rd_data);
  modport bank (input addr, input wr_stb, input wr_data, output rd_data);
endinterface

/* logic/pmsar_reg_bank.sv */
// Control, status, identifier, advertisement and partner registers.
// Assumes live status inputs are synchronous to the core clock.
`timescale 1ns/1ps
module pmsar_reg_bank #(
  parameter logic [15:0] ID_HIGH = 16'h1234,  // Arbitrary value
  parameter logic [15:0] ID_LOW = 16'h5678    // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Register access
  pmsar_mgmt_if.bank mgmt,
  // Live port state
  input wire logic link_up_in,
  input wire logic an_done_in,
  input wire logic far_fault_in,
  input wire logic partner_pause_in,
  // Settings
  output logic [2:0] ctrl_out,
  output logic [15:0] advert_out
);
  logic stat_link;
  logic stat_an_done;
  logic stat_fef;
  logic lpa_pause;

  function automatic logic wr_hit(input logic stb, input logic [4:0] a, input logic [4:0] r);
    wr_hit = stb && (a == r);
  endfunction

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_out <= pmsar_pkg::CTRL_RESET;
    end else if (wr_hit(mgmt.wr_stb, mgmt.addr, pmsar_pkg::REG_CTRL)) begin
      ctrl_out <= mgmt.wr_data[2:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      advert_out <= pmsar_pkg::ADV_RESET;
    end else if (wr_hit(mgmt.wr_stb, mgmt.addr, pmsar_pkg::REG_ADV)) begin
      advert_out <= (mgmt.wr_data & pmsar_pkg::ADV_RW_MASK) | pmsar_pkg::SELECTOR;
    end
  end

  // Live status, cleared by reset
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stat_link <= 1'b0;
      stat_an_done <= 1'b0;
      stat_fef <= 1'b0;
      lpa_pause <= 1'b0;
    end else begin
      stat_link <= link_up_in;
      stat_an_done <= an_done_in;
      stat_fef <= far_fault_in && !ctrl_out[pmsar_pkg::CTRL_FEF_DIS_BIT];
      lpa_pause <= partner_pause_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mgmt.rd_data <= 16'h0000;
    end else begin
      unique case (mgmt.addr)
        pmsar_pkg::REG_CTRL: mgmt.rd_data <= {13'h0000, ctrl_out};
        pmsar_pkg::REG_STAT: begin
          mgmt.rd_data <= pmsar_pkg::STAT_FIXED;
          mgmt.rd_data[pmsar_pkg::STAT_AN_DONE_BIT] <= stat_an_done;
          mgmt.rd_data[pmsar_pkg::STAT_FEF_BIT] <= stat_fef;
          mgmt.rd_data[pmsar_pkg::STAT_LINK_BIT] <= stat_link;
        end
        pmsar_pkg::REG_ID_HI: mgmt.rd_data <= ID_HIGH;
        pmsar_pkg::REG_ID_LO: mgmt.rd_data <= ID_LOW;
        pmsar_pkg::REG_ADV: mgmt.rd_data <= advert_out;
        pmsar_pkg::REG_LPA: begin
          mgmt.rd_data <= pmsar_pkg::SELECTOR;
          mgmt.rd_data[pmsar_pkg::LPA_PAUSE_BIT] <= lpa_pause;
        end
        default: mgmt.rd_data <= 16'h0000;
      endcase
    end
  end
endmodule

/* logic/pmsar_top.sv */
// Per-port management slice: serial management frame engine plus the
// control outputs that steer transmit, indicators and fault detection.
// Assumes MDC and MDIO are already synchronous to the core clock and MDC
// runs well below half the core clock rate.
`timescale 1ns/1ps
module pmsar_top #(
  parameter logic [4:0] PHY_ADDR = 5'h01,
  parameter int LED_W = 2,
  parameter logic [15:0] ID_HIGH = 16'h1234,  // Arbitrary value
  parameter logic [15:0] ID_LOW = 16'h5678    // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Management pins
  input wire logic mdc_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n_out,
  // Live port state
  input wire logic link_up_in,
  input wire logic an_done_in,
  input wire logic far_fault_in,
  input wire logic partner_pause_in,
  // Transmit and indicator paths
  input wire logic tx_en_in,
  input wire logic [LED_W-1:0] led_in,
  output logic tx_en_out,
  output logic [LED_W-1:0] led_out,
  // Settings toward the port
  output logic fef_detect_en_out,
  output logic adv_pause_out,
  output logic adv_100fd_out,
  output logic adv_100hd_out,
  output logic adv_10fd_out,
  output logic adv_10hd_out
);
  pmsar_mgmt_if mgmt ();

  pmsar_pkg::pmsar_state_t state;
  logic mdc_prev;
  logic mdc_rise;
  logic [5:0] pre_cnt;
  logic [3:0] bit_cnt;
  logic [11:0] head;
  logic [11:0] next_head;
  logic is_read;
  logic [15:0] shift;
  logic [4:0] reg_addr;
  logic wr_stb;
  logic [15:0] wr_data;
  logic [2:0] ctrl;
  logic [15:0] advert;
  logic head_last;
  logic head_match;
  logic turn_first;
  logic turn_second;
  logic data_body;
  logic data_last;
  logic next_mdio;
  logic next_oe_n;
  wire logic [LED_W-1:0] led_gated;

  // True when the sequencer sits at a given bit of a given field
  function automatic logic step_is(input pmsar_pkg::pmsar_state_t s,
                                   input pmsar_pkg::pmsar_state_t want,
                                   input logic [3:0] cnt,
                                   input logic [3:0] want_cnt);
    step_is = (s == want) && (cnt == want_cnt);
  endfunction

  // Header aimed at this port with a read or write opcode
  function automatic logic frame_is_ours(input logic [11:0] h, input logic [4:0] pa);
    frame_is_ours = (h[9:5] == pa)
      && (h[11:10] == pmsar_pkg::OP_READ || h[11:10] == pmsar_pkg::OP_WRITE);
  endfunction

  assign head_last = step_is(state, pmsar_pkg::ST_HEAD, bit_cnt, pmsar_pkg::HEAD_LAST);
  assign head_match = frame_is_ours(next_head, PHY_ADDR);
  assign turn_first = step_is(state, pmsar_pkg::ST_TURN, bit_cnt, 4'h0);
  assign turn_second = (state == pmsar_pkg::ST_TURN) && (bit_cnt != 4'h0);
  assign data_last = step_is(state, pmsar_pkg::ST_DATA, bit_cnt, pmsar_pkg::DATA_LAST);
  assign data_body = (state == pmsar_pkg::ST_DATA) && (bit_cnt != pmsar_pkg::DATA_LAST);

  assign next_head = {head[10:0], mdio_in};
  assign mdc_rise = mdc_in && !mdc_prev;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mdc_prev <= 1'b0;
    end else begin
      mdc_prev <= mdc_in;
    end
  end

  // Preamble: consecutive ones seen while idle, saturating
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_cnt <= 6'h00;
    end else if (state != pmsar_pkg::ST_IDLE) begin
      pre_cnt <= 6'h00;
    end else if (mdc_rise) begin
      if (!mdio_in) begin
        pre_cnt <= 6'h00;
      end else if (pre_cnt != pmsar_pkg::PREAMBLE_LEN) begin
        pre_cnt <= pre_cnt + 6'h01;
      end
    end
  end

  // Frame sequencer, advanced on each MDC rising edge
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= pmsar_pkg::ST_IDLE;
    end else if (mdc_rise) begin
      unique case (state)
        pmsar_pkg::ST_IDLE: begin
          if (!mdio_in && pre_cnt == pmsar_pkg::PREAMBLE_LEN) begin
            state <= pmsar_pkg::ST_START;
          end
        end
        pmsar_pkg::ST_START: begin
          if (mdio_in) begin
            state <= pmsar_pkg::ST_HEAD;
          end else begin
            state <= pmsar_pkg::ST_IDLE;
          end
        end
        pmsar_pkg::ST_HEAD: begin
          // Other addresses and bad opcodes: frame ignored, pin left free
          if (head_last && head_match) begin
            state <= pmsar_pkg::ST_TURN;
          end else if (head_last) begin
            state <= pmsar_pkg::ST_IDLE;
          end
        end
        pmsar_pkg::ST_TURN: begin
          if (turn_second) begin
            state <= pmsar_pkg::ST_DATA;
          end
        end
        pmsar_pkg::ST_DATA: begin
          if (data_last) begin
            state <= pmsar_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= pmsar_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Bit position inside the header, turnaround and data fields
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bit_cnt <= 4'h0;
    end else if (mdc_rise) begin
      unique case (state)
        pmsar_pkg::ST_IDLE: begin
          bit_cnt <= bit_cnt;
        end
        pmsar_pkg::ST_START: begin
          bit_cnt <= 4'h0;
        end
        pmsar_pkg::ST_HEAD: begin
          bit_cnt <= head_last ? 4'h0 : bit_cnt + 4'h1;
        end
        pmsar_pkg::ST_TURN: begin
          bit_cnt <= turn_second ? 4'h0 : bit_cnt + 4'h1;
        end
        pmsar_pkg::ST_DATA: begin
          bit_cnt <= data_last ? 4'h0 : bit_cnt + 4'h1;
        end
        default: begin
          bit_cnt <= bit_cnt;
        end
      endcase
    end
  end

  // Header bits collected MSB first
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      head <= 12'h000;
    end else if (mdc_rise && state == pmsar_pkg::ST_HEAD) begin
      head <= next_head;
    end
  end

  // Operation and register index, latched once a header is accepted
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      is_read <= 1'b0;
    end else if (mdc_rise && head_last && head_match) begin
      is_read <= next_head[11:10] == pmsar_pkg::OP_READ;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_addr <= 5'h00;
    end else if (mdc_rise && head_last && head_match) begin
      reg_addr <= next_head[4:0];
    end
  end

  // Data shifter: read word loaded at turnaround, write word collected
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift <= 16'h0000;
    end else if (mdc_rise) begin
      if (turn_first) begin
        shift <= mgmt.rd_data;
      end else if (state == pmsar_pkg::ST_DATA) begin
        shift <= is_read ? {shift[14:0], 1'b0} : {shift[14:0], mdio_in};
      end
    end
  end

  // Pin level: zero in second turnaround bit, then data MSB first
  always_comb begin
    next_mdio = mdio_out;
    if (mdc_rise && is_read) begin
      if (turn_first) begin
        next_mdio = 1'b0;
      end else if (state == pmsar_pkg::ST_TURN) begin
        next_mdio = shift[15];
      end else if (data_body) begin
        next_mdio = shift[14];
      end else begin
        next_mdio = 1'b1;
      end
    end else if (mdc_rise && state != pmsar_pkg::ST_DATA) begin
      next_mdio = 1'b1;
    end
  end

  // Pin released outside the answer of a read frame
  always_comb begin
    next_oe_n = mdio_oe_n_out;
    if (mdc_rise && is_read) begin
      if (turn_first) begin
        next_oe_n = 1'b0;
      end else if (state != pmsar_pkg::ST_TURN && !data_body) begin
        next_oe_n = 1'b1;
      end
    end else if (mdc_rise && state != pmsar_pkg::ST_DATA) begin
      next_oe_n = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mdio_out <= 1'b1;
    end else begin
      mdio_out <= next_mdio;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mdio_oe_n_out <= 1'b1;
    end else begin
      mdio_oe_n_out <= next_oe_n;
    end
  end

  // One-cycle write strobe at the last data bit of a write frame
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_stb <= 1'b0;
    end else begin
      wr_stb <= mdc_rise && !is_read && data_last;
    end
  end

  // Write word completed with the last data bit
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_data <= 16'h0000;
    end else if (mdc_rise && data_last) begin
      wr_data <= {shift[14:0], mdio_in};
    end
  end

  assign mgmt.addr = reg_addr;
  assign mgmt.wr_stb = wr_stb;
  assign mgmt.wr_data = wr_data;

  pmsar_reg_bank #(
    .ID_HIGH(ID_HIGH),
    .ID_LOW(ID_LOW)
  ) u_bank (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .mgmt(mgmt.bank),
    .link_up_in(link_up_in),
    .an_done_in(an_done_in),
    .far_fault_in(far_fault_in),
    .partner_pause_in(partner_pause_in),
    .ctrl_out(ctrl),
    .advert_out(advert)
  );

  // Transmit gating, registered
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_en_out <= 1'b0;
    end else begin
      tx_en_out <= tx_en_in && !ctrl[pmsar_pkg::CTRL_TX_DIS_BIT];
    end
  end

  // Fault detection enable, low while the disable bit is set
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fef_detect_en_out <= 1'b0;
    end else begin
      fef_detect_en_out <= !ctrl[pmsar_pkg::CTRL_FEF_DIS_BIT];
    end
  end

  // Indicator gating, one gate per indicator, then registered
  for (genvar i = 0; i < LED_W; i++) begin : g_led
    assign led_gated[i] = led_in[i] && !ctrl[pmsar_pkg::CTRL_LED_DIS_BIT];
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      led_out <= '0;
    end else begin
      led_out <= led_gated;
    end
  end

  assign adv_pause_out = advert[pmsar_pkg::ADV_PAUSE_BIT];
  assign adv_100fd_out = advert[pmsar_pkg::ADV_100FD_BIT];
  assign adv_100hd_out = advert[pmsar_pkg::ADV_100HD_BIT];
  assign adv_10fd_out = advert[pmsar_pkg::ADV_10FD_BIT];
  assign adv_10hd_out = advert[pmsar_pkg::ADV_10HD_BIT];
endmodule

/* bench/pmsar_host_model.sv */
// Station management controller model: drives MDC and serial frames.
// Assumes the bench resolves the shared data wire with a pull-up.
`timescale 1ns/1ps
module pmsar_host_model (
  // Clock
  input wire logic clk_sys_in,
  // Management wire
  input wire logic mdio_in,
  output logic mdc_out,
  output logic mdio_out,
  output logic mdio_en_out
);
  initial begin
    mdc_out = 1'b0;
    mdio_out = 1'b1;
    mdio_en_out = 1'b0;
  end

  // Drive during MDC low, sample the wire as MDC rises
  task automatic bit_cyc(input logic d, input logic en, output logic s);
    @(posedge clk_sys_in);
    mdc_out <= 1'b0;
    mdio_out <= d;
    mdio_en_out <= en;
    repeat (3) @(posedge clk_sys_in);
    s = mdio_in;
    mdc_out <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] f;
    logic s;
    f = {2'b01, op, pa, ra, 2'b10, wd};
    for (int i = 0; i < 32; i++) begin
      bit_cyc(1'b1, 1'b1, s);
    end
    // Released from turnaround on for reads
    for (int i = 31; i >= 0; i--) begin
      bit_cyc(f[i], (op == 2'b01) || (i > 17), s);
      if (i < 16) begin
        rd[i] = s;
      end
    end
    @(posedge clk_sys_in);
    mdc_out <= 1'b0;
    mdio_en_out <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
  endtask
endmodule

/* bench/pmsar_top_assertions.sv */
// Checker on the management slice top ports.
// Assumes one core clock domain and the asynchronous active low reset.
`timescale 1ns/1ps
module pmsar_checker #(
  parameter int LED_W = 2
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic mdc_in,
  input wire logic mdio_out,
  input wire logic mdio_oe_n_out,
  input wire logic tx_en_in,
  input wire logic [LED_W-1:0] led_in,
  input wire logic tx_en_out,
  input wire logic [LED_W-1:0] led_out,
  input wire logic fef_detect_en_out,
  input wire logic adv_pause_out,
  input wire logic adv_100fd_out,
  input wire logic adv_100hd_out,
  input wire logic adv_10fd_out,
  input wire logic adv_10hd_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  fef_reset_a: assert property ($rose(rst_n_in) |=> fef_detect_en_out)
    else $error("fault detection not enabled after reset");
  tx_gate_a: assert property (tx_en_out |-> $past(tx_en_in))
    else $error("transmit enable without raw enable");
  led_gate_a: assert property ((led_out & ~$past(led_in)) == '0)
    else $error("indicator on without raw indicator");
  pause_reset_a: assert property ($rose(rst_n_in) |-> adv_pause_out)
    else $error("pause advertisement not one after reset");
  fast_reset_a: assert property ($rose(rst_n_in) |-> adv_100fd_out && adv_100hd_out)
    else $error("100 Mbit advertisement not one after reset");
  slow_reset_a: assert property ($rose(rst_n_in) |-> adv_10fd_out && adv_10hd_out)
    else $error("10 Mbit advertisement not one after reset");
  drive_start_a: assert property ($fell(mdio_oe_n_out) |-> !mdio_out)
    else $error("read drive does not start with zero");
  drive_hold_a: assert property ($fell(mdio_oe_n_out) |-> !mdio_oe_n_out [*8])
    else $error("read drive dropped early");
  out_timing_a: assert property ($changed(mdio_out) |-> $past(mdc_in) && !$past(mdc_in, 2))
    else $error("data pin changed off the clock rise");
  out_idle_a: assert property (mdio_oe_n_out |-> mdio_out)
    else $error("data pin not high while released");
endmodule

bind pmsar_top pmsar_checker #(.LED_W(LED_W)) u_chk (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .mdc_in(mdc_in),
  .mdio_out(mdio_out), .mdio_oe_n_out(mdio_oe_n_out), .tx_en_in(tx_en_in),
  .led_in(led_in), .tx_en_out(tx_en_out), .led_out(led_out),
  .fef_detect_en_out(fef_detect_en_out), .adv_pause_out(adv_pause_out),
  .adv_100fd_out(adv_100fd_out), .adv_100hd_out(adv_100hd_out),
  .adv_10fd_out(adv_10fd_out), .adv_10hd_out(adv_10hd_out)
);

/* bench/phy_mgmt_status_ability_regs_test.sv */
// Testbench: register reads and writes through the serial management frame.
// Assumes the host model and the checker are compiled beforehand.
`timescale 1ns/1ps
module phy_mgmt_status_ability_regs_test;
  localparam logic [15:0] ID_H = 16'h0a5c;  // Arbitrary value
  localparam logic [15:0] ID_L = 16'h3e71;  // Arbitrary value
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic link_up_in = 1'b0;
  logic an_done_in = 1'b0;
  logic far_fault_in = 1'b0;
  logic partner_pause_in = 1'b0;
  logic tx_en_in = 1'b0;
  logic [1:0] led_in = 2'b00;
  logic mdc, host_d, host_en, mdio_out, mdio_oe_n_out, tx_en_out, fef;
  logic a_p, a_fh, a_hh, a_fl, a_hl;
  logic [1:0] led_out;
  logic [15:0] rv;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  // Pulled-up wire
  wire mdio = (host_en ? host_d : 1'b1) & (mdio_oe_n_out | mdio_out);

  always #12.5 clk_sys_in = ~clk_sys_in;

  pmsar_host_model host (.clk_sys_in(clk_sys_in), .mdio_in(mdio), .mdc_out(mdc),
    .mdio_out(host_d), .mdio_en_out(host_en));

  pmsar_top #(.ID_HIGH(ID_H), .ID_LOW(ID_L)) dut (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .mdc_in(mdc), .mdio_in(mdio), .mdio_out(mdio_out),
    .mdio_oe_n_out(mdio_oe_n_out), .link_up_in(link_up_in), .an_done_in(an_done_in),
    .far_fault_in(far_fault_in), .partner_pause_in(partner_pause_in),
    .tx_en_in(tx_en_in), .led_in(led_in), .tx_en_out(tx_en_out), .led_out(led_out),
    .fef_detect_en_out(fef), .adv_pause_out(a_p), .adv_100fd_out(a_fh),
    .adv_100hd_out(a_hh), .adv_10fd_out(a_fl), .adv_10hd_out(a_hl));

  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] g;
    host.frame(pmsar_pkg::OP_READ, 5'h01, a, 16'h0000, g);
    chk($sformatf("reg %0d", a), e, g);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    host.frame(pmsar_pkg::OP_WRITE, 5'h01, a, d, rv);
  endtask

  task automatic chk_pins(input logic [15:0] e);
    chk("port pins", e, {8'h00, tx_en_out, led_out, fef, 4'h0});
  endtask

  task automatic chk_adv(input logic [15:0] e);
    chk("advert pins", e, {11'h000, a_p, a_fh, a_hh, a_fl, a_hl});
  endtask

  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      report_and_stop;
    end
  end

  initial begin
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    rd(pmsar_pkg::REG_CTRL, 16'h0000);
    rd(pmsar_pkg::REG_STAT, 16'h7808);
    rd(pmsar_pkg::REG_ID_HI, ID_H);
    rd(pmsar_pkg::REG_ID_LO, ID_L);
    rd(pmsar_pkg::REG_ADV, 16'h05e1);
    rd(pmsar_pkg::REG_LPA, 16'h0001);
    rd(5'h06, 16'h0000);
    link_up_in <= 1'b1;
    an_done_in <= 1'b1;
    far_fault_in <= 1'b1;
    partner_pause_in <= 1'b1;
    tx_en_in <= 1'b1;
    led_in <= 2'b11;
    rd(pmsar_pkg::REG_STAT, 16'h783c);
    rd(pmsar_pkg::REG_LPA, 16'h0401);
    wr(pmsar_pkg::REG_CTRL, 16'hffff);
    rd(pmsar_pkg::REG_CTRL, 16'h0007);
    rd(pmsar_pkg::REG_STAT, 16'h782c);
    chk_pins(16'h0000);
    // Disables cleared before link is relied on
    wr(pmsar_pkg::REG_CTRL, 16'h0000);
    chk_pins(16'h00f0);
    tx_en_in <= 1'b0;
    led_in <= 2'b01;
    repeat (2) @(posedge clk_sys_in);
    chk_pins(16'h0030);
    tx_en_in <= 1'b1;
    led_in <= 2'b11;
    rd(pmsar_pkg::REG_STAT, 16'h783c);
    wr(pmsar_pkg::REG_ADV, 16'h0000);
    rd(pmsar_pkg::REG_ADV, 16'h0001);
    chk_adv(16'h0000);
    wr(pmsar_pkg::REG_ADV, 16'hffff);
    rd(pmsar_pkg::REG_ADV, 16'h05e1);
    chk_adv(16'h001f);
    wr(pmsar_pkg::REG_STAT, 16'h0000);
    wr(pmsar_pkg::REG_ID_HI, 16'h0000);
    wr(pmsar_pkg::REG_LPA, 16'h0000);
    rd(pmsar_pkg::REG_STAT, 16'h783c);
    rd(pmsar_pkg::REG_ID_HI, ID_H);
    rd(pmsar_pkg::REG_LPA, 16'h0401);
    // Foreign port address must be ignored
    host.frame(pmsar_pkg::OP_WRITE, 5'h02, pmsar_pkg::REG_ADV, 16'h0000, rv);
    rd(pmsar_pkg::REG_ADV, 16'h05e1);
    wr(pmsar_pkg::REG_ADV, 16'h0000);
    wr(pmsar_pkg::REG_CTRL, 16'h0007);
    rst_n_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    rd(pmsar_pkg::REG_ADV, 16'h05e1);
    rd(pmsar_pkg::REG_CTRL, 16'h0000);
    report_and_stop;
  end
endmodule
